// >>> src/fftc_field_flag_trim.sv
`timescale 1ns/100ps
`include "fftc_regs.svh"

module fftc_field_flag_trim
  import fftc_pkg::*;
#(
  parameter int SAMPLE_GAP_CYC = `FFTC_SAMPLE_GAP_CYC
) (
  // system clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // serial link, mode 3
  input  wire logic       spi_sck,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  // front end field magnitude in mT
  input  wire fftc_byte_t field_mt,
  // bias trim to the hall front end
  output fftc_byte_t      bias_trim_amount,
  output logic            x_axis_trim_enable,
  output logic            y_axis_trim_enable,
  output fftc_byte_t      x_bias_reduction,
  output fftc_byte_t      y_bias_reduction,
  // field flag pins
  output logic            field_low_flag,
  output logic            field_high_flag
);
  localparam int GW = $clog2(SAMPLE_GAP_CYC + 1);

  // ****************
  // elaboration checks
  // ****************
  if (SAMPLE_GAP_CYC * `FFTC_CLK_PERIOD_NS <= `FFTC_SPUR_MAX_NS) begin : g_gap_short
    $error("sample gap must outlast the longest low flag spur");
  end
  if (SAMPLE_GAP_CYC * `FFTC_CLK_PERIOD_NS >= `FFTC_SPUR_SPACING_NS) begin : g_gap_long
    $error("sample gap must be shorter than the spur spacing");
  end
  // shift widths, field slices and the threshold layout below are fixed
  if (`FFTC_FRAME_BITS != 16) begin : g_frame_bits
    $error("link logic is sized for 16-bit frames");
  end
  if (`FFTC_ADDR_MSB - `FFTC_ADDR_LSB != 4) begin : g_addr_bits
    $error("register address must be five bits wide");
  end
  if (`FFTC_THR_LOW_MSB - `FFTC_THR_LOW_LSB != 2) begin : g_low_code
    $error("low threshold code must be three bits wide");
  end
  if (`FFTC_THR_HIGH_MSB - `FFTC_THR_HIGH_LSB != 2) begin : g_high_code
    $error("high threshold code must be three bits wide");
  end
  if (`FFTC_THR_HIGH_LSB != 2) begin : g_thr_base
    $error("threshold codes must sit in bits 7 to 2");
  end

  // ****************
  // link domain: receive
  // ****************
  logic [14:0] rx_shift_reg;
  logic [14:0] rx_shift_next;
  logic [4:0]  rx_cnt_reg;
  logic [4:0]  rx_cnt_next;
  logic [15:0] rx_word_reg;
  logic [15:0] rx_word_next;
  logic        rx_tgl_reg;
  logic        rx_tgl_next;

  always_comb begin
    rx_shift_next = {rx_shift_reg[13:0], spi_mosi};
    rx_cnt_next   = (rx_cnt_reg == 5'(`FFTC_FRAME_BITS)) ? rx_cnt_reg : rx_cnt_reg + 5'h01;
    rx_word_next  = rx_word_reg;
    rx_tgl_next   = rx_tgl_reg;
    if (rx_cnt_reg == 5'(`FFTC_FRAME_BITS - 1)) begin
      rx_word_next = {rx_shift_reg, spi_mosi};
      rx_tgl_next  = ~rx_tgl_reg;
    end
  end

  // bit counter restarts with every frame select
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      rx_shift_reg <= 15'h0000;
      rx_cnt_reg   <= 5'h00;
    end else begin
      rx_shift_reg <= rx_shift_next;
      rx_cnt_reg   <= rx_cnt_next;
    end
  end

  always_ff @(posedge spi_sck or negedge resetn) begin
    if (!resetn) begin
      rx_word_reg <= 16'h0000;
      rx_tgl_reg  <= 1'b0;
    end else begin
      rx_word_reg <= rx_word_next;
      rx_tgl_reg  <= rx_tgl_next;
    end
  end

  // ****************
  // link domain: transmit
  // ****************
  logic [15:0] resp_reg;
  logic [4:0]  tx_cnt_reg;
  logic [4:0]  tx_cnt_next;
  logic        miso_reg;
  logic        miso_next;

  // resp_reg is held still by the system side while a frame runs
  always_comb begin
    tx_cnt_next = tx_cnt_reg;
    miso_next   = 1'b0;
    if (tx_cnt_reg < 5'(`FFTC_FRAME_BITS)) begin
      miso_next   = resp_reg[4'(5'(`FFTC_FRAME_BITS - 1) - tx_cnt_reg)];
      tx_cnt_next = tx_cnt_reg + 5'h01;
    end
  end

  always_ff @(negedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      tx_cnt_reg <= 5'h00;
      miso_reg   <= 1'b0;
    end else begin
      tx_cnt_reg <= tx_cnt_next;
      miso_reg   <= miso_next;
    end
  end

  assign spi_miso = miso_reg;

  // ****************
  // crossing into the system domain
  // ****************
  logic [1:0] sync_q;
  logic       tgl_seen_reg;
  logic       frame_ev;

  // select enters inverted, so the synchroniser's reset value reads as
  // deselected and the miso enable stays low coming out of reset
  fftc_sync #(
    .W       (2)
  ) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       ({rx_tgl_reg, ~spi_cs_n}),
    .q       (sync_q)
  );

  assign frame_ev = sync_q[1] ^ tgl_seen_reg;

  // ****************
  // field flags
  // ****************
  logic [1:0]  flag_w;
  fftc_code_t  code_w [2];
  logic [5:0]  thr_reg;
  logic [5:0]  thr_next;

  assign code_w[0] = thr_reg[`FFTC_THR_LOW_MSB-2:`FFTC_THR_LOW_LSB-2];
  assign code_w[1] = thr_reg[`FFTC_THR_HIGH_MSB-2:`FFTC_THR_HIGH_LSB-2];

  // each flag compares against its own code only
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    fftc_field_cmp #(
      .HIGH_SIDE (i == 1)
    ) u_cmp (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .field_mt  (field_mt),
      .code      (code_w[i]),
      .flag      (flag_w[i])
    );
  end

  // flags drive only these pins and the status byte; no angle path here
  assign field_low_flag  = flag_w[0];
  assign field_high_flag = flag_w[1];

  // ****************
  // low flag samples
  // ****************
  logic [GW-1:0] gap_cnt_reg;
  logic [GW-1:0] gap_cnt_next;
  logic          sample_a_reg;
  logic          sample_a_next;
  logic          sample_b_reg;
  logic          sample_b_next;

  // two samples of field-present, one gap apart, so a lone spur hits one
  always_comb begin
    gap_cnt_next  = gap_cnt_reg + GW'(1);
    sample_a_next = sample_a_reg;
    sample_b_next = sample_b_reg;
    if (gap_cnt_reg == GW'(SAMPLE_GAP_CYC - 1)) begin
      gap_cnt_next  = '0;
      sample_a_next = ~flag_w[0];
      sample_b_next = sample_a_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gap_cnt_reg  <= '0;
      sample_a_reg <= 1'b0;
      sample_b_reg <= 1'b0;
    end else begin
      gap_cnt_reg  <= gap_cnt_next;
      sample_a_reg <= sample_a_next;
      sample_b_reg <= sample_b_next;
    end
  end

  // ****************
  // register file
  // ****************
  fftc_byte_t bias_reg;
  fftc_byte_t bias_next;
  logic [1:0] trim_en_reg;
  logic [1:0] trim_en_next;
  logic [15:0] resp_next;
  fftc_byte_t status_w;
  fftc_byte_t rd_w;
  fftc_cmd_e  cmd_w;
  logic [4:0] addr_w;
  fftc_byte_t data_w;

  function automatic fftc_byte_t reg_rd(input logic [4:0] addr, input fftc_byte_t bias,
                                        input logic [1:0] ten, input logic [5:0] thr,
                                        input fftc_byte_t status);
    case (addr)
      `FFTC_ADDR_BIAS_TRIM: reg_rd = bias;
      `FFTC_ADDR_TRIM_EN:   reg_rd = {6'h00, ten};
      `FFTC_ADDR_THRESHOLD: reg_rd = {thr, 2'h0};
      `FFTC_ADDR_STATUS:    reg_rd = status;
      default:              reg_rd = 8'h00;
    endcase
  endfunction : reg_rd

  // live flag levels at decode time
  always_comb begin
    status_w                        = 8'h00;
    status_w[`FFTC_ST_HIGH_BIT]     = flag_w[1];
    status_w[`FFTC_ST_LOW_BIT]      = flag_w[0];
    status_w[`FFTC_ST_SAMPLE_A_BIT] = sample_a_reg;
    status_w[`FFTC_ST_SAMPLE_B_BIT] = sample_b_reg;
  end

  assign cmd_w  = fftc_cmd_e'(rx_word_reg[`FFTC_CMD_MSB:`FFTC_CMD_LSB]);
  assign addr_w = rx_word_reg[`FFTC_ADDR_MSB:`FFTC_ADDR_LSB];
  assign data_w = rx_word_reg[7:0];

  // rx_word_reg is stable here: it changed a full sync delay before frame_ev
  always_comb begin
    bias_next    = bias_reg;
    trim_en_next = trim_en_reg;
    thr_next     = thr_reg;
    if (frame_ev && cmd_w == FFTC_CMD_WRITE) begin
      case (addr_w)
        `FFTC_ADDR_BIAS_TRIM: bias_next = data_w;
        `FFTC_ADDR_TRIM_EN:   trim_en_next = data_w[1:0];
        `FFTC_ADDR_THRESHOLD: thr_next = data_w[7:2];
        default:              bias_next = bias_reg;
      endcase
    end
  end

  // answer for the next frame, taken from the post-write register state
  always_comb begin
    rd_w      = reg_rd(addr_w, bias_next, trim_en_next, thr_next, status_w);
    resp_next = resp_reg;
    if (frame_ev) begin
      case (cmd_w)
        FFTC_CMD_READ:  resp_next = {rd_w, 8'h00};
        FFTC_CMD_WRITE: resp_next = {rd_w, 8'h00};
        default:        resp_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bias_reg     <= `FFTC_RST_BIAS_TRIM;
      trim_en_reg  <= `FFTC_RST_TRIM_EN;
      thr_reg      <= 6'(`FFTC_RST_THRESHOLD >> 2);
      resp_reg     <= 16'h0000;
      tgl_seen_reg <= 1'b0;
    end else begin
      bias_reg     <= bias_next;
      trim_en_reg  <= trim_en_next;
      thr_reg      <= thr_next;
      resp_reg     <= resp_next;
      tgl_seen_reg <= sync_q[1];
    end
  end

  // ****************
  // trim outputs
  // ****************
  fftc_byte_t bias_out_reg;
  logic       x_en_reg;
  logic       y_en_reg;
  fftc_byte_t x_red_reg;
  fftc_byte_t x_red_next;
  fftc_byte_t y_red_reg;
  fftc_byte_t y_red_next;
  logic       oe_reg;
  logic       oe_next;

  // both enables give the same reduction on both axes
  always_comb begin
    x_red_next = trim_en_reg[`FFTC_TRIM_X_BIT] ? bias_reg : 8'h00;
    y_red_next = trim_en_reg[`FFTC_TRIM_Y_BIT] ? bias_reg : 8'h00;
    oe_next    = sync_q[0];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bias_out_reg <= `FFTC_RST_BIAS_TRIM;
      x_en_reg     <= 1'b0;
      y_en_reg     <= 1'b0;
      x_red_reg    <= 8'h00;
      y_red_reg    <= 8'h00;
      oe_reg       <= 1'b0;
    end else begin
      bias_out_reg <= bias_reg;
      x_en_reg     <= trim_en_reg[`FFTC_TRIM_X_BIT];
      y_en_reg     <= trim_en_reg[`FFTC_TRIM_Y_BIT];
      x_red_reg    <= x_red_next;
      y_red_reg    <= y_red_next;
      oe_reg       <= oe_next;
    end
  end

  assign bias_trim_amount   = bias_out_reg;
  assign x_axis_trim_enable = x_en_reg;
  assign y_axis_trim_enable = y_en_reg;
  assign x_bias_reduction   = x_red_reg;
  assign y_bias_reduction   = y_red_reg;
  assign spi_miso_oe        = oe_reg;
endmodule : fftc_field_flag_trim

// >>> inc/fftc_regs.svh
`ifndef FFTC_REGS_SVH
`define FFTC_REGS_SVH
// How it works
// - an 8-bit unsigned bias trim amount, 0 to 255, sets bias reduction
// - x and y trim enables, 0 off and 1 on, pick reduced axis
// - both enables on reduce both axes equally, giving no side-shaft correction
// - bias trim amount comes up zero, so no reduction until written
// - low flag when field drops under low point, high flag above high point
// - both flags switch with 6 mT hysteresis between rising and falling points
// - register 6 holds low code in bits 7:5, high code in 4:2
// - code 000 switches at 26/20 mT, about 14 mT per step, 126/120 at 111
// - low code may exceed high code; each flag judged on its own
// - register 27 shows high bit 7, low bit 6, samples bits 3 and 2
// - read command to register 27 returns its contents in the next frame
// - flags never alter or gate the angle value
// - low flag may glitch 1.3 to 1.5 us, glitches at least 100 us apart
// - trim amount at 0x2, x enable bit 0 and y bit 1 of 0x3

// ****************
// register map
// ****************
`define FFTC_ADDR_BIAS_TRIM  5'h02
`define FFTC_ADDR_TRIM_EN    5'h03
`define FFTC_ADDR_THRESHOLD  5'h06
`define FFTC_ADDR_STATUS     5'h1B
`define FFTC_TRIM_X_BIT      0
`define FFTC_TRIM_Y_BIT      1
`define FFTC_THR_LOW_MSB     7
`define FFTC_THR_LOW_LSB     5
`define FFTC_THR_HIGH_MSB    4
`define FFTC_THR_HIGH_LSB    2
`define FFTC_ST_HIGH_BIT     7
`define FFTC_ST_LOW_BIT      6
`define FFTC_ST_SAMPLE_A_BIT 3
`define FFTC_ST_SAMPLE_B_BIT 2
`define FFTC_RST_BIAS_TRIM   8'h00
`define FFTC_RST_TRIM_EN     2'h0
`define FFTC_RST_THRESHOLD   8'h1C

// ****************
// frame layout
// ****************
`define FFTC_FRAME_BITS      16
`define FFTC_CMD_MSB         15
`define FFTC_CMD_LSB         13
`define FFTC_ADDR_MSB        12
`define FFTC_ADDR_LSB        8

// ****************
// field points and timing
// ****************
`define FFTC_RISE_TABLE      64'h7E70_6254_4638_291A
`define FFTC_HYST_MT         8'h06
`define FFTC_CLK_PERIOD_NS   25
`define FFTC_SAMPLE_GAP_NS   2000
`define FFTC_SAMPLE_GAP_CYC  ((`FFTC_SAMPLE_GAP_NS + `FFTC_CLK_PERIOD_NS - 1) / `FFTC_CLK_PERIOD_NS)
`define FFTC_SPUR_MAX_NS     1500
`define FFTC_SPUR_SPACING_NS 100000

`endif

// >>> inc/fftc_pkg.sv
`include "fftc_regs.svh"
package fftc_pkg;
  typedef logic [7:0] fftc_byte_t;
  typedef logic [2:0] fftc_code_t;

  typedef enum logic [2:0] {
    FFTC_CMD_READ  = 3'h2,
    FFTC_CMD_WRITE = 3'h4
  } fftc_cmd_e;

  // rising-field switching point of a threshold code, in mT
  function automatic fftc_byte_t fftc_rise_mt(input fftc_code_t code);
    logic [63:0] table_v;
    table_v = `FFTC_RISE_TABLE;
    fftc_rise_mt = table_v[{code, 3'h0} +: 8];
  endfunction : fftc_rise_mt
endpackage : fftc_pkg

// >>> src/fftc_sync.sv
`timescale 1ns/100ps
module fftc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // crossing signals
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule : fftc_sync

// >>> src/fftc_field_cmp.sv
`timescale 1ns/100ps
`include "fftc_regs.svh"

module fftc_field_cmp
  import fftc_pkg::*;
#(
  parameter bit HIGH_SIDE = 1'b0
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // field and threshold
  input  wire fftc_byte_t field_mt,
  input  wire fftc_code_t code,
  // flag
  output logic            flag
);
  fftc_byte_t rise_mt;
  fftc_byte_t fall_mt;
  logic       flag_reg;
  logic       flag_next;

  always_comb begin
    rise_mt   = fftc_rise_mt(code);
    fall_mt   = rise_mt - `FFTC_HYST_MT;
    flag_next = flag_reg;
    if (HIGH_SIDE) begin
      if (!flag_reg && field_mt >= rise_mt) begin
        flag_next = 1'b1;
      end else if (flag_reg && field_mt < fall_mt) begin
        flag_next = 1'b0;
      end
    end else begin
      if (!flag_reg && field_mt < fall_mt) begin
        flag_next = 1'b1;
      end else if (flag_reg && field_mt >= rise_mt) begin
        flag_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule : fftc_field_cmp

// >>> verif/fftc_field_flag_trim_asserts.sv
`timescale 1ns/100ps
module fftc_field_flag_trim_asserts
  import fftc_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // link pins
  input wire logic       spi_sck,
  input wire logic       spi_cs_n,
  input wire logic       spi_mosi,
  input wire logic       spi_miso,
  input wire logic       spi_miso_oe,
  // front end
  input wire fftc_byte_t field_mt,
  input wire fftc_byte_t bias_trim_amount,
  input wire logic       x_axis_trim_enable,
  input wire logic       y_axis_trim_enable,
  input wire fftc_byte_t x_bias_reduction,
  input wire fftc_byte_t y_bias_reduction,
  // flag pins
  input wire logic       field_low_flag,
  input wire logic       field_high_flag
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_x_reduction_map: assert property (
    x_bias_reduction == (x_axis_trim_enable ? bias_trim_amount : 8'h00)) else $error("x reduction wrong");
  a_y_reduction_map: assert property (
    y_bias_reduction == (y_axis_trim_enable ? bias_trim_amount : 8'h00)) else $error("y reduction wrong");
  a_both_axes_equal: assert property (
    x_axis_trim_enable && y_axis_trim_enable |-> x_bias_reduction == y_bias_reduction)
    else $error("both axes not reduced alike");
  a_trim_reset_zero: assert property (
    $rose(resetn) |-> bias_trim_amount == 8'h00 && !x_axis_trim_enable && !y_axis_trim_enable)
    else $error("trim not zero after reset");
  a_high_rise_point: assert property (
    $rose(field_high_flag) |-> $past(field_mt) >= 8'h1A) else $error("high flag set below lowest point");
  a_high_fall_point: assert property (
    $fell(field_high_flag) |-> $past(field_mt) < 8'h78) else $error("high flag cleared above top point");
  a_low_rise_point: assert property (
    $rose(field_low_flag) |-> $past(field_mt) < 8'h78) else $error("low flag set above top point");
  a_low_fall_point: assert property (
    $fell(field_low_flag) |-> $past(field_mt) >= 8'h1A) else $error("low flag cleared below lowest point");
  a_miso_idle_zero: assert property (
    spi_cs_n && $past(spi_cs_n) |-> !spi_miso) else $error("miso not low outside frame");
  a_oe_follows_cs: assert property (
    spi_miso_oe == !$past(spi_cs_n, 3)) else $error("miso enable does not follow select");

  c_high_seen: cover property ($rose(field_high_flag));
  c_low_seen: cover property ($rose(field_low_flag));
  c_both_trim: cover property (x_axis_trim_enable && y_axis_trim_enable);
endmodule : fftc_field_flag_trim_asserts

bind fftc_field_flag_trim fftc_field_flag_trim_asserts fftc_field_flag_trim_asserts_i (
  .clk_sys(clk_sys), .resetn(resetn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .field_mt(field_mt), .bias_trim_amount(bias_trim_amount),
  .x_axis_trim_enable(x_axis_trim_enable), .y_axis_trim_enable(y_axis_trim_enable),
  .x_bias_reduction(x_bias_reduction), .y_bias_reduction(y_bias_reduction),
  .field_low_flag(field_low_flag), .field_high_flag(field_high_flag)
);

// >>> verif/fftc_spi_host.sv
`timescale 1ns/100ps
module fftc_spi_host (
  // link pins
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // ****
  // frame engine
  // ****
  initial begin
    spi_sck  = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // mode 3, msb first; read answer arrives in the next frame
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #7;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #80;
      spi_sck  = 1'b0;
      spi_mosi = tx[i];
      #80;
      spi_sck = 1'b1;
      rx[i]   = spi_miso;
    end
    #40;
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    // frame length a whole number of system clocks, so select never meets a clock edge
    #418;
  endtask : xfer

  function automatic logic corrected_low(input logic [7:0] st);
    return !(st[3] | st[2]);
  endfunction : corrected_low

  function automatic logic filtered_low(input logic first, input logic second);
    return first & second;
  endfunction : filtered_low

  function automatic logic low_from_high(input logic high);
    return !high;
  endfunction : low_from_high
endmodule : fftc_spi_host

// >>> verif/fftc_field_flag_trim_test.sv
`timescale 1ns/100ps
`include "fftc_regs.svh"
module fftc_field_flag_trim_test
  import fftc_pkg::*;
;
  // ****
  // wiring
  // ****
  logic       clk_sys;
  logic       resetn;
  logic       spi_sck;
  logic       spi_cs_n;
  logic       spi_mosi;
  logic       spi_miso;
  logic       spi_miso_oe;
  fftc_byte_t field_mt;
  fftc_byte_t bias_trim_amount;
  fftc_byte_t x_bias_reduction;
  fftc_byte_t y_bias_reduction;
  logic       x_axis_trim_enable;
  logic       y_axis_trim_enable;
  logic       field_low_flag;
  logic       field_high_flag;
  logic       first_low;
  fftc_byte_t rd_data;
  logic [15:0] rx_word;
  int         err_count = 0;
  int         cmp_count = 0;
  fftc_byte_t rise_pt [8] = '{8'h1A, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7E};

  fftc_field_flag_trim #(.SAMPLE_GAP_CYC(80)) fftc_field_flag_trim_i (
    .clk_sys(clk_sys), .resetn(resetn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .field_mt(field_mt), .bias_trim_amount(bias_trim_amount),
    .x_axis_trim_enable(x_axis_trim_enable), .y_axis_trim_enable(y_axis_trim_enable),
    .x_bias_reduction(x_bias_reduction), .y_bias_reduction(y_bias_reduction),
    .field_low_flag(field_low_flag), .field_high_flag(field_high_flag)
  );
  fftc_spi_host fftc_spi_host_i (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ****
  // tasks
  // ****
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic xchk(input string what, input fftc_byte_t exp, input fftc_byte_t got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : xchk

  task automatic wr(input logic [4:0] addr, input fftc_byte_t data);
    logic [15:0] rx;
    fftc_spi_host_i.xfer({FFTC_CMD_WRITE, addr, data}, rx);
  endtask : wr

  task automatic rd_chk(input string what, input logic [4:0] addr, input fftc_byte_t exp);
    logic [15:0] rx;
    fftc_spi_host_i.xfer({FFTC_CMD_READ, addr, 8'h00}, rx);
    fftc_spi_host_i.xfer(16'h0000, rx);
    rd_data = rx[15:8];
    xchk(what, exp, rd_data);
  endtask : rd_chk

  task automatic set_field(input fftc_byte_t v);
    @(posedge clk_sys);
    field_mt <= v;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : set_field

  task automatic settle();
    repeat (200) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic flags_chk(input logic lo, input logic hi);
    xchk("flag_pins", {6'h00, lo, hi}, {6'h00, field_low_flag, field_high_flag});
  endtask : flags_chk

  // ****
  // tests
  // ****
  initial begin
    resetn   <= 1'b0;
    field_mt <= 8'h3C;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    settle();
    xchk("amount_rst", 8'h00, bias_trim_amount);
    rd_chk("bias_rst", `FFTC_ADDR_BIAS_TRIM, 8'h00);
    rd_chk("en_rst", `FFTC_ADDR_TRIM_EN, 8'h00);
    rd_chk("thr_rst", `FFTC_ADDR_THRESHOLD, 8'h1C);
    rd_chk("status_idle", `FFTC_ADDR_STATUS, 8'h0C);
    fftc_spi_host_i.xfer(16'h0000, rx_word);
    xchk("unknown_cmd", 8'h00, rx_word[15:8]);
    wr(`FFTC_ADDR_STATUS, 8'hFF);
    wr(5'h1F, 8'h55);
    rd_chk("status_ro", `FFTC_ADDR_STATUS, 8'h0C);
    wr(`FFTC_ADDR_BIAS_TRIM, 8'hFF);
    rd_chk("bias_max", `FFTC_ADDR_BIAS_TRIM, 8'hFF);
    wr(`FFTC_ADDR_BIAS_TRIM, 8'hAB);
    for (int en = 0; en < 4; en++) begin
      wr(`FFTC_ADDR_TRIM_EN, {6'h3F, en[1:0]});
      rd_chk("en_rb", `FFTC_ADDR_TRIM_EN, {6'h00, en[1:0]});
      xchk("en_pins", {6'h00, en[1:0]}, {6'h00, y_axis_trim_enable, x_axis_trim_enable});
      xchk("x_red", en[0] ? 8'hAB : 8'h00, x_bias_reduction);
      xchk("y_red", en[1] ? 8'hAB : 8'h00, y_bias_reduction);
      xchk("amount", 8'hAB, bias_trim_amount);
    end
    // hysteresis sweep over every threshold code
    set_field(8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(`FFTC_ADDR_THRESHOLD, {c[2:0], c[2:0], 2'h3});
      rd_chk("thr_rb", `FFTC_ADDR_THRESHOLD, {c[2:0], c[2:0], 2'h0});
      set_field(rise_pt[c] - 8'h01);
      flags_chk(1'b1, 1'b0);
      set_field(rise_pt[c]);
      flags_chk(1'b0, 1'b1);
      set_field(rise_pt[c] - `FFTC_HYST_MT);
      flags_chk(1'b0, 1'b1);
      set_field(rise_pt[c] - `FFTC_HYST_MT - 8'h01);
      flags_chk(1'b1, 1'b0);
    end
    settle();
    rd_chk("status_low", `FFTC_ADDR_STATUS, 8'h40);
    xchk("corrected", 8'h01, {7'h00, fftc_spi_host_i.corrected_low(rd_data)});
    xchk("inv_high", {7'h00, rd_data[6]}, {7'h00, fftc_spi_host_i.low_from_high(rd_data[7])});
    first_low = rd_data[6];
    rd_chk("status_low2", `FFTC_ADDR_STATUS, 8'h40);
    xchk("twice_low", 8'h01, {7'h00, fftc_spi_host_i.filtered_low(first_low, rd_data[6])});
    set_field(8'h7E);
    settle();
    rd_chk("status_high", `FFTC_ADDR_STATUS, 8'h8C);
    wr(`FFTC_ADDR_THRESHOLD, 8'hE0);
    set_field(8'h3C);
    flags_chk(1'b1, 1'b1);
    // reset in mid-run brings trim, thresholds and flags back to defaults
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    settle();
    xchk("en_rst2", 8'h00, {6'h00, y_axis_trim_enable, x_axis_trim_enable});
    xchk("amount_rst2", 8'h00, bias_trim_amount);
    rd_chk("thr_rst2", `FFTC_ADDR_THRESHOLD, 8'h1C);
    flags_chk(1'b0, 1'b0);
    wrap_up();
  end

  initial begin
    #1000000;
    err_count++;
    $display("watchdog expired before tests ended");
    wrap_up();
  end
endmodule : fftc_field_flag_trim_test
